// [rtl/adcc_top.sv]
/*
 * Converter control block: AXI4-Lite register file, start sequencing, pad control, request flag.
 * Assumes the analog front end presents each input as an 8-bit sample on analog_inputs.
 */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
module adcc_top #(
    parameter int unsigned CONV_TICKS = adcc_pkg::CONV_TICKS_DEFAULT
) (
    // Clock, reset, enable
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        ce,
    // AXI4-Lite write address and data
    input  wire logic [adcc_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                  awprot,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    // AXI4-Lite write response
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    // AXI4-Lite read
    input  wire logic [adcc_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                  arprot,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic [31:0]                      rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    // Analog inputs
    input  wire adcc_pkg::adcc_samples_type  analog_inputs,
    // Second port pad control
    input  wire logic [7:0]                  second_gpio_port_oe_req,
    input  wire logic [7:0]                  second_gpio_port_pullup_opt,
    output adcc_pkg::adcc_gpio_type          second_gpio_port_ctl,
    // Request line
    output logic                             converter_irq
);
    import adcc_pkg::*;

    adcc_ctrl_type     ctrl_r;
    adcc_ctrl_type     wr_ctrl;
    logic [7:0]        clkset_r;
    logic              irq_en_r;
    logic              irq_flag_r;
    logic              start_q_r;
    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [7:0]        wr_data_r;
    logic              wr_lane_r;
    logic              wr_go;
    logic              wr_ctrl_sel;
    logic              wr_clk_sel;
    logic              wr_irq_sel;
    logic              wr_mapped;
    logic              start_rise;
    logic              start_conv;
    logic              conv_done;
    logic              conv_tick;
    logic [7:0]        conv_result;
    logic [31:0]       rd_word;
    logic              rd_mapped;

    // Prescaler restarts with the converter
    adcc_clkdiv u_clkdiv (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .sel     (clkset_r[CLK_SEL_LSB +: 2]),
        .clr     (ctrl_r.start),
        .tick    (conv_tick)
    );

    // eight channels in, eight bits out
    adcc_core #(
        .CONV_TICKS (CONV_TICKS)
    ) u_core (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .hold       (ctrl_r.start),
        .start_conv (start_conv),
        .tick       (conv_tick),
        .channel    (ctrl_r.channel),
        .samples    (analog_inputs),
        .done       (conv_done),
        .result     (conv_result)
    );

    // Bus handshakes; enable low also stops the bus
    assign awready = ce && !aw_held_r && !bvalid;
    assign wready  = ce && !w_held_r && !bvalid;
    assign arready = ce && !rvalid;
    assign wr_go   = aw_held_r && w_held_r && !bvalid;

    // Write decode, only the low byte lane carries data
    assign wr_ctrl_sel = wr_go && wr_lane_r && (wr_addr_r == ADDR_CONTROL);
    assign wr_clk_sel  = wr_go && wr_lane_r && (wr_addr_r == ADDR_CLKSET);
    assign wr_irq_sel  = wr_go && wr_lane_r && (wr_addr_r == ADDR_IRQ);
    assign wr_mapped   = (wr_addr_r == ADDR_CONTROL) || (wr_addr_r == ADDR_CLKSET) ||
                         (wr_addr_r == ADDR_IRQ) || (wr_addr_r == ADDR_RESULT);
    assign wr_ctrl     = adcc_ctrl_type'(wr_data_r);

    // edge of the start bit from software
    assign start_rise = wr_ctrl_sel && wr_ctrl.start && !ctrl_r.start;
    // falling edge seen one cycle after the write
    assign start_conv = start_q_r && !ctrl_r.start;

    // Address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= 8'h00;
            wr_lane_r <= 1'b0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_held_r <= 1'b1;
                wr_addr_r <= awaddr;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_r  <= 1'b1;
                wr_data_r <= wdata[7:0];
                wr_lane_r <= wstrb[0];
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r.start     <= CONTROL_RESET[7];
            ctrl_r.pin_count <= CONTROL_RESET[5:3];
            ctrl_r.channel   <= CONTROL_RESET[2:0];
            start_q_r        <= 1'b0;
        end else if (ce) begin
            start_q_r <= ctrl_r.start;
            if (wr_ctrl_sel) begin
                ctrl_r.start     <= wr_ctrl.start;
                ctrl_r.pin_count <= wr_ctrl.pin_count;
                ctrl_r.channel   <= wr_ctrl.channel;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r.pending <= CONTROL_RESET[6];
        end else if (ce) begin
            if (start_rise) begin
                ctrl_r.pending <= 1'b1;
            end else if (conv_done) begin
                ctrl_r.pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clkset_r <= CLKSET_RESET;
        end else if (ce && wr_clk_sel) begin
            clkset_r <= 8'h00;
            clkset_r[CLK_SEL_LSB +: 2] <= wr_data_r[CLK_SEL_LSB +: 2];
            clkset_r[CLK_TEST_BIT]     <= wr_data_r[CLK_TEST_BIT];
        end
    end

    // request flag, set beats a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_r   <= 1'b0;
            irq_flag_r <= 1'b0;
        end else if (ce) begin
            if (wr_irq_sel) begin
                irq_en_r <= wr_data_r[IRQ_EN_BIT];
            end
            if (conv_done) begin
                irq_flag_r <= 1'b1;
            end else if (wr_irq_sel && wr_data_r[IRQ_FLAG_BIT]) begin
                irq_flag_r <= 1'b0;
            end
        end
    end

    assign converter_irq = irq_flag_r && irq_en_r;

    // Read mux
    always_comb begin
        rd_word   = 32'h0000_0000;
        rd_mapped = 1'b1;
        unique case (araddr)
            ADDR_RESULT:  rd_word[7:0] = conv_result;
            ADDR_CONTROL: rd_word[7:0] = ctrl_r;
            ADDR_CLKSET:  rd_word[7:0] = clkset_r;
            ADDR_IRQ: begin
                rd_word[IRQ_EN_BIT]   = irq_en_r;
                rd_word[IRQ_FLAG_BIT] = irq_flag_r;
            end
            default:      rd_mapped = 1'b0;
        endcase
    end

    // Read data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // thermometer mask; code 7 covers all eight lines
    // analog lines lose digital paths and pull-up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            second_gpio_port_ctl <= '0;
        end else if (ce) begin
            second_gpio_port_ctl.analog_sel <= (ctrl_r.pin_count == 3'h7) ? 8'hFF :
                                               8'((9'h001 << ctrl_r.pin_count) - 9'h001);
            second_gpio_port_ctl.input_en   <= (ctrl_r.pin_count == 3'h7) ? 8'h00 :
                                               ~8'((9'h001 << ctrl_r.pin_count) - 9'h001);
            second_gpio_port_ctl.output_en  <= second_gpio_port_oe_req &
                                               ~((ctrl_r.pin_count == 3'h7) ? 8'hFF :
                                               8'((9'h001 << ctrl_r.pin_count) - 9'h001));
            second_gpio_port_ctl.pullup_en  <= second_gpio_port_pullup_opt &
                                               ~((ctrl_r.pin_count == 3'h7) ? 8'hFF :
                                               8'((9'h001 << ctrl_r.pin_count) - 9'h001));
        end
    end

    a_start_sets_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && start_rise |=> ctrl_r.pending && ctrl_r.start)
        else $error("start rising edge did not set pending");

    a_done_clears_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done |=> !ctrl_r.pending && irq_flag_r)
        else $error("completion did not clear pending and set request");

    a_pend_fall_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(ctrl_r.pending) |-> $past(conv_done) && conv_result == $past(analog_inputs[u_core.chan_r]))
        else $error("pending fell without result update");

    a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq_flag_r) |-> $past(conv_done) && !$past(ctrl_r.start))
        else $error("request flag set without a completed conversion");

    a_analog_count: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(ce) |-> $countones(second_gpio_port_ctl.analog_sel) ==
            (($past(ctrl_r.pin_count) == 3'h7) ? 8 : int'($past(ctrl_r.pin_count))))
        else $error("analog line count does not match pin count field");

    a_analog_isolated: assert property (@(posedge aclk) disable iff (!aresetn)
        (second_gpio_port_ctl.analog_sel & (second_gpio_port_ctl.pullup_en |
            second_gpio_port_ctl.output_en | second_gpio_port_ctl.input_en)) == 8'h00)
        else $error("analog line keeps a digital function");

    c_conversion_done: cover property (@(posedge aclk) disable iff (!aresetn) conv_done);
    c_irq_raised:      cover property (@(posedge aclk) disable iff (!aresetn) $rose(converter_irq));
    c_start_pulse:     cover property (@(posedge aclk) disable iff (!aresetn) start_rise ##[1:20] start_conv);
    c_conv_aborted:    cover property (@(posedge aclk) disable iff (!aresetn)
        start_rise && u_core.state_r == ADCC_CONVERT);
    c_slow_divider:    cover property (@(posedge aclk) disable iff (!aresetn)
        conv_done && clkset_r[CLK_SEL_LSB +: 2] == 2'h3);

endmodule : adcc_top

// [rtl/adcc_pkg.sv]
/*
 * Shared constants, types and register map of the converter control block.
 * Assumes one 10 MHz clock, a synchronous active-low reset and an AXI4-Lite master.
 */
// Overview of operation
// - Eight input channels, eight-bit result.
// - Low three control bits pick channel.
// - Pin count n makes lowest n lines analog; code 7 here makes all eight.
// - Analog lines lose digital function and pull-up.
// - Control bit 6 pending, reads 0 when done.
// - Start rising edge resets converter, sets pending.
// - Converter held in reset while start high.
// - Start falling edge begins conversion.
// - Completion clears pending, sets interrupt request.
// - Result register holds the completed value.
// - Clock select: /2, /8, /32, 11 undefined.
package adcc_pkg;

    // Bus geometry and responses
    localparam int unsigned ADDR_W      = 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_RESULT  = 8'h21;
    localparam logic [7:0] IDX_CONTROL = 8'h22;
    localparam logic [7:0] IDX_CLKSET  = 8'h23;
    localparam logic [7:0] IDX_IRQ     = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_RESULT  = ADDR_W'(IDX_RESULT * 4);
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'(IDX_CONTROL * 4);
    localparam logic [ADDR_W-1:0] ADDR_CLKSET  = ADDR_W'(IDX_CLKSET * 4);
    localparam logic [ADDR_W-1:0] ADDR_IRQ     = ADDR_W'(IDX_IRQ * 4);

    // Field positions outside the control struct
    localparam int unsigned CLK_SEL_LSB  = 0;
    localparam int unsigned CLK_TEST_BIT = 7;
    localparam int unsigned IRQ_EN_BIT   = 0;
    localparam int unsigned IRQ_FLAG_BIT = 1;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CLKSET_RESET  = 8'h00;
    localparam logic [7:0] RESULT_RESET  = 8'h00;

    // Converter clock dividers and conversion length in converter ticks
    localparam int unsigned DIV_CODE0          = 2;
    localparam int unsigned DIV_CODE1          = 8;
    localparam int unsigned DIV_CODE2          = 32;
    localparam int unsigned CONV_TICKS_DEFAULT = 16;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       start;
        logic       pending;
        logic [2:0] pin_count;
        logic [2:0] channel;
    } adcc_ctrl_type;

    // Digitised value presented on each of the eight inputs
    typedef logic [7:0][7:0] adcc_samples_type;

    // Second port pad controls, one bit per line
    typedef struct packed {
        logic [7:0] analog_sel;
        logic [7:0] input_en;
        logic [7:0] output_en;
        logic [7:0] pullup_en;
    } adcc_gpio_type;

    // Converter sequencing states
    typedef enum logic [1:0] {
        ADCC_IDLE    = 2'b00,
        ADCC_HOLD    = 2'b01,
        ADCC_CONVERT = 2'b10
    } adcc_state_type;

endpackage : adcc_pkg

// [rtl/adcc_clkdiv.sv]
/*
 * Converter clock prescaler: one-cycle tick at the selected division of aclk.
 * Assumes clr is held while the converter sits in reset, so each conversion starts aligned.
 */
`timescale 1ns/100ps
module adcc_clkdiv (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    // Control
    input  wire logic [1:0] sel,
    input  wire logic       clr,
    // Tick out
    output logic            tick
);
    import adcc_pkg::*;

    logic [4:0] count_r;
    logic [4:0] last;

    always_comb begin
        unique case (sel)
            2'h0:    last = 5'(DIV_CODE0 - 1);
            2'h1:    last = 5'(DIV_CODE1 - 1);
            default: last = 5'(DIV_CODE2 - 1); // Undefined code runs slowest, the safe side
        endcase
    end

    assign tick = (count_r == last) && !clr;

    // Prescaler count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= 5'h00;
        end else if (ce) begin
            if (clr || tick || count_r > last) begin
                count_r <= 5'h00;
            end else begin
                count_r <= count_r + 5'h01;
            end
        end
    end

    a_div8_period: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !clr && sel == 2'h1 && tick) ##1 (ce && !clr && sel == 2'h1) [*7] |=> tick)
        else $error("divide by eight tick spacing wrong");

endmodule : adcc_clkdiv

// [rtl/adcc_core.sv]
/*
 * Conversion sequencer: holds in reset, latches the channel, counts ticks, captures the result.
 * Assumes hold is the start bit level and start_conv pulses on its falling edge.
 */
`timescale 1ns/100ps
module adcc_core #(
    parameter int unsigned CONV_TICKS = adcc_pkg::CONV_TICKS_DEFAULT
) (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       ce,
    // Sequencing
    input  wire logic                       hold,
    input  wire logic                       start_conv,
    input  wire logic                       tick,
    input  wire logic [2:0]                 channel,
    // Sample source and result
    input  wire adcc_pkg::adcc_samples_type samples,
    output logic                            done,
    output logic [7:0]                      result
);
    import adcc_pkg::*;

    localparam int unsigned CW = $clog2(CONV_TICKS + 1);
    localparam logic [CW-1:0] LAST = CW'(CONV_TICKS - 1);

    adcc_state_type state_r;
    logic [CW-1:0]  count_r;
    logic [2:0]     chan_r;

    // completes after a fixed tick count
    assign done = ce && (state_r == ADCC_CONVERT) && tick && (count_r == LAST) && !hold;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ADCC_IDLE;
        end else if (ce) begin
            if (hold) begin
                state_r <= ADCC_HOLD;
            end else begin
                unique case (state_r)
                    ADCC_IDLE: begin
                        state_r <= ADCC_IDLE;
                    end
                    ADCC_HOLD: begin
                        if (start_conv) begin
                            state_r <= ADCC_CONVERT;
                        end
                    end
                    ADCC_CONVERT: begin
                        if (done) begin
                            state_r <= ADCC_IDLE;
                        end
                    end
                    default: begin
                        state_r <= ADCC_IDLE;
                    end
                endcase
            end
        end
    end

    // Tick counter, cleared whenever not converting
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= '0;
        end else if (ce) begin
            if (hold || state_r != ADCC_CONVERT) begin
                count_r <= '0;
            end else if (tick) begin
                count_r <= count_r + CW'(1);
            end
        end
    end

    // channel frozen for the whole conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_r <= 3'h0;
        end else if (ce && state_r == ADCC_HOLD && start_conv) begin
            chan_r <= channel;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result <= RESULT_RESET;
        end else if (done) begin
            result <= samples[chan_r];
        end
    end

    a_hold_resets_seq: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && hold |=> state_r == ADCC_HOLD && count_r == '0)
        else $error("converter not held in reset while start high");

    a_fall_starts_conv: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !hold && start_conv && state_r == ADCC_HOLD |=> state_r == ADCC_CONVERT)
        else $error("falling start did not begin conversion");

    a_result_of_channel: assert property (@(posedge aclk) disable iff (!aresetn)
        done |=> result == $past(samples[chan_r]))
        else $error("result not taken from selected channel");

endmodule : adcc_core

// [tb/adcc_tb_top.sv]
/*
 * Self-checking bench for the converter control block: registers, pads, conversions.
 * Assumes adcc_pkg and adcc_top; drives AXI4-Lite itself, no partner model.
 */
`timescale 1ns/100ps
module adcc_tb_top;
    import adcc_pkg::*;
    // Short conversion keeps the run brief
    localparam int unsigned CT = 2;
    logic             aclk    = 1'b0;
    logic             aresetn = 1'b0;
    logic [7:0]       awaddr  = 8'h00;
    logic [7:0]       araddr  = 8'h00;
    logic [31:0]      wdata   = 32'h0;
    logic             awvalid = 1'b0;
    logic             wvalid  = 1'b0;
    logic             bready  = 1'b0;
    logic             arvalid = 1'b0;
    logic             rready  = 1'b0;
    logic [7:0]       oe_req  = 8'h00;
    logic [7:0]       pu_opt  = 8'h00;
    adcc_samples_type smp     = '0;
    logic             awready, wready, bvalid, arready, rvalid, converter_irq;
    logic [1:0]       bresp, rresp;
    logic [31:0]      rdata;
    adcc_gpio_type    gctl;
    int               num_errors = 0;
    int               n_checks   = 0;
    logic [17:0]      rq[$];
    logic [1:0]       wq[$];

    always #50 aclk = ~aclk;

    adcc_top #(.CONV_TICKS(CT)) dut (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .analog_inputs(smp), .second_gpio_port_oe_req(oe_req),
        .second_gpio_port_pullup_opt(pu_opt), .second_gpio_port_ctl(gctl),
        .converter_irq(converter_irq)
    );

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask : chk

    // Write: address and data offered together, response noted for the monitor
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs);
        @(posedge aclk);
        wq.push_back(rs);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(negedge aclk); while (!(awready && wready));
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(negedge aclk); while (!bvalid);
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr

    // Read: expected value and care mask noted for the monitor
    task automatic rd(input logic [7:0] a, e, m, input logic [1:0] rs, output logic [7:0] d);
        @(posedge aclk);
        rq.push_back({rs, m, e});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        d = rdata[7:0];
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd

    // Monitor: oldest note against each completed response
    always @(posedge aclk) begin : mon
        logic [17:0] e;
        if (rvalid && rready) begin
            e = rq.pop_front();
            chk(32'({rresp, rdata[7:0] & e[15:8]}), 32'({e[17:16], e[7:0] & e[15:8]}), "read");
        end
        if (bvalid && bready) begin
            chk(32'(bresp), 32'(wq.pop_front()), "write resp");
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Watchdog sized well above the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_sim();
    end

    initial begin : main
        logic [7:0] d;
        logic [7:0] an;
        int         c;
        int         dv;
        void'($urandom(44089));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CONTROL, CONTROL_RESET, 8'hFF, RESP_OKAY, d);
        rd(ADDR_CLKSET, CLKSET_RESET, 8'hFF, RESP_OKAY, d);
        wr(ADDR_RESULT, 8'hFF, RESP_OKAY);
        rd(ADDR_RESULT, RESULT_RESET, 8'hFF, RESP_OKAY, d);
        wr(8'hFC, 8'h01, RESP_SLVERR);
        rd(8'hFC, 8'h00, 8'h00, RESP_SLVERR, d);
        // Test bit left clear; unused bits must read back as zero
        wr(ADDR_CLKSET, 8'h7F, RESP_OKAY);
        rd(ADDR_CLKSET, 8'h03, 8'hFF, RESP_OKAY, d);
        $display("test registers done");
        oe_req <= 8'($urandom());
        pu_opt <= 8'($urandom());
        // Every pin count, each change written together with a start pulse; top code makes all eight analog
        for (int n = 0; n < 8; n++) begin
            wr(ADDR_CONTROL, 8'(8'h80 | (n << 3)), RESP_OKAY);
            wr(ADDR_CONTROL, 8'(n << 3), RESP_OKAY);
            repeat (2) @(negedge aclk);
            an = (n == 7) ? 8'hFF : 8'((1 << n) - 1);
            chk(32'(gctl), {an, ~an, oe_req & ~an, pu_opt & ~an}, "pads");
        end
        wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
        // Last pulse's conversion must finish before the request is armed and cleared
        repeat (100) @(posedge aclk);
        rd(ADDR_CONTROL, 8'h00, 8'hFF, RESP_OKAY, d);
        wr(ADDR_IRQ, 8'h03, RESP_OKAY);
        $display("test pads done");
        // Every channel, divider codes cycled; code 3 runs as the slowest
        for (int i = 0; i < 8; i++) begin
            dv = (i % 4 == 0) ? 2 : (i % 4 == 1) ? 8 : 32;
            wr(ADDR_CLKSET, 8'(i % 4), RESP_OKAY);
            smp <= {$urandom(), $urandom()};
            wr(ADDR_CONTROL, 8'(8'h80 | i), RESP_OKAY);
            rd(ADDR_CONTROL, 8'(8'hC0 | i), 8'hFF, RESP_OKAY, d);
            if (i == 3) begin
                repeat (100) @(posedge aclk);
                rd(ADDR_CONTROL, 8'(8'hC0 | i), 8'hFF, RESP_OKAY, d);
            end
            wr(ADDR_CONTROL, 8'(i), RESP_OKAY);
            c = 0;
            while (converter_irq !== 1'b1 && c < 400) begin
                @(negedge aclk);
                c++;
            end
            chk(32'(c >= CT * dv - 4 && c <= CT * dv + 6), 32'h1, "duration");
            rd(ADDR_CONTROL, 8'(i), 8'hFF, RESP_OKAY, d);
            rd(ADDR_RESULT, smp[i], 8'hFF, RESP_OKAY, d);
            rd(ADDR_IRQ, 8'h03, 8'hFF, RESP_OKAY, d);
            wr(ADDR_IRQ, 8'h03, RESP_OKAY);
            @(negedge aclk);
            chk(32'(converter_irq), 32'h0, "request cleared");
        end
        $display("test conversions done");
        end_sim();
    end
endmodule : adcc_tb_top
